// [hw/dcscp_core.sv]
// Purpose: Serial configuration port and load-state decode, two channels
// Assumes: Serial pins and strobes are asynchronous; sampled on core_clk
// Notes:   Calibration store resets only on power-on (por_n), not on nrst
`timescale 1ns/10ps
module dcscp_core (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic         por_n,
  input  wire logic         clk_en,
  input  wire logic         sclk,
  input  wire logic         cs_n,
  input  wire logic         serial_in,
  input  wire logic         transfer_strobe_n,
  input  wire logic [1:0]   lowleak_pin_n,
  input  wire logic [1:0]   receive_ctl,
  output logic              serial_out,
  output logic [1:0][2:0]   droop_amp_sel,
  output logic [1:0][3:0]   out_res_trim,
  output logic [1:0][2:0]   comp_deadband_sel,
  output logic [1:0]        load_force_off,
  output logic [1:0]        load_diag_on,
  output logic [1:0]        term_select,
  output logic [1:0]        lowleak_soft,
  output logic [1:0]        lowleak_active,
  output logic [1:0]        load_on,
  output logic [1:0]        clamp_enable,
  output logic [1:0][15:0]  level_word,
  output logic [1:0][15:0]  cal_word,
  output logic              frame_applied
);
  // Two-stage synchronisers; stage one read only by stage two
  logic [4:0] s1;
  logic [4:0] s2;
  logic [4:0] s3;
  logic [1:0] ll1;
  logic [1:0] ll2;
  logic [1:0] rc1;
  logic [1:0] rc2;
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      s1 <= 5'h1f;
      s2 <= 5'h1f;
      s3 <= 5'h1f;
      ll1 <= 2'h3;
      ll2 <= 2'h3;
      rc1 <= 2'h0;
      rc2 <= 2'h0;
    end
    else if (clk_en)
    begin
      s1 <= {transfer_strobe_n, serial_in, cs_n, sclk, 1'b1};
      s2 <= s1;
      s3 <= s2;
      ll1 <= lowleak_pin_n;
      ll2 <= ll1;
      rc1 <= receive_ctl;
      rc2 <= rc1;
    end
  end

  logic sclk_rise;
  logic cs_rise;
  logic strobe_fall;
  logic din;
  logic cs_low;
  logic strobe_n;
  assign sclk_rise   = s2[1] && !s3[1];
  assign cs_rise     = s2[2] && !s3[2];
  assign cs_low      = !s2[2];
  assign din         = s2[3];
  assign strobe_n    = s2[4];
  assign strobe_fall = !s2[4] && s3[4];

  // Shift register: only the last 24 bits survive
  logic [dcscp_pkg::FRAME_W-1:0] shreg;
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      shreg <= '0;
    else if (clk_en && cs_low && sclk_rise)
      shreg <= {shreg[dcscp_pkg::FRAME_W-2:0], din};
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      serial_out <= 1'b0;
    else if (clk_en)
      serial_out <= shreg[dcscp_pkg::FRAME_W-1];
  end

  // Frame fields
  logic       f_cal;
  logic       f_bc;
  logic [1:0] f_ch;
  logic [3:0] f_reg;
  logic       f_null;
  assign f_cal  = shreg[dcscp_pkg::CAL_BIT];
  assign f_bc   = shreg[dcscp_pkg::BCAST_BIT];
  assign f_ch   = shreg[dcscp_pkg::CH_HI:dcscp_pkg::CH_LO];
  assign f_reg  = shreg[dcscp_pkg::REG_HI:dcscp_pkg::REG_LO];
  assign f_null = f_bc && (f_ch == 2'h3);

  // Staging registers hold one pending non-calibration frame
  logic        stg_valid;
  logic        stg_bc;
  logic        stg_ch;
  logic [3:0]  stg_reg;
  logic [15:0] stg_data;
  logic        direct;
  logic        deferred;
  assign direct   = cs_rise && !f_cal && !f_null && !strobe_n;
  assign deferred = stg_valid && strobe_fall;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      stg_valid <= 1'b0;
      stg_bc    <= 1'b0;
      stg_ch    <= 1'b0;
      stg_reg   <= 4'h0;
      stg_data  <= 16'h0000;
    end
    else if (clk_en)
    begin
      if (cs_rise && !f_cal && !f_null)
      begin
        stg_valid <= strobe_n;
        stg_bc    <= f_bc;
        stg_ch    <= f_ch[0];
        stg_reg   <= f_reg;
        stg_data  <= shreg[dcscp_pkg::DATA_W-1:0];
      end
      else if (deferred)
        stg_valid <= 1'b0;
    end
  end

  // Write source: direct path wins, else deferred staging
  logic        w_en;
  logic        w_bc;
  logic        w_ch;
  logic [3:0]  w_reg;
  logic [15:0] w_data;
  assign w_en   = direct || deferred;
  assign w_bc   = direct ? f_bc : stg_bc;
  assign w_ch   = direct ? f_ch[0] : stg_ch;
  assign w_reg  = direct ? f_reg : stg_reg;
  assign w_data = direct ? shreg[dcscp_pkg::DATA_W-1:0] : stg_data;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      frame_applied <= 1'b0;
    else if (clk_en)
      frame_applied <= w_en;
  end

  // Per-channel storage and decode
  logic [1:0][15:0] ctl;
  for (genvar c = 0; c < dcscp_pkg::NCHAN; c++)
  begin : g_ch
    logic hit;
    logic cal_hit;
    assign hit = w_en && (w_bc || w_ch == c[0]);
    assign cal_hit = cs_rise && f_cal && !f_null && (f_bc || f_ch[0] == c[0]);

    always_ff @(posedge core_clk)
    begin
      if (!nrst)
      begin
        ctl[c]        <= dcscp_pkg::CTL_RST;
        level_word[c] <= dcscp_pkg::LEVEL_RST;
      end
      else if (clk_en && hit)
      begin
        if (w_reg == dcscp_pkg::REG_CTL)
          ctl[c] <= w_data;
        else
          level_word[c] <= w_data;
      end
    end

    // Calibration only follows power-on reset
    always_ff @(posedge core_clk)
    begin
      if (!por_n)
        cal_word[c] <= dcscp_pkg::CAL_RST;
      else if (clk_en && cal_hit)
        cal_word[c] <= shreg[dcscp_pkg::DATA_W-1:0];
    end

    assign droop_amp_sel[c]     = ctl[c][dcscp_pkg::DROOP_HI:dcscp_pkg::DROOP_LO];
    assign comp_deadband_sel[c] = ctl[c][dcscp_pkg::COMP_DEADBAND_SEL_HI:dcscp_pkg::COMP_DEADBAND_SEL_LO];
    assign out_res_trim[c]      = ctl[c][dcscp_pkg::TRIM_HI:dcscp_pkg::TRIM_LO];
    assign load_force_off[c]    = ctl[c][dcscp_pkg::LDOFF_BIT];
    assign load_diag_on[c]      = ctl[c][dcscp_pkg::LDDIAG_BIT];
    assign term_select[c]       = ctl[c][dcscp_pkg::TERM_BIT];
    assign lowleak_soft[c]      = ctl[c][dcscp_pkg::LLEAK_BIT];

    // Load state decode from registered inputs
    always_ff @(posedge core_clk)
    begin
      if (!nrst)
      begin
        lowleak_active[c] <= 1'b0;
        load_on[c]        <= 1'b0;
        clamp_enable[c]   <= 1'b0;
      end
      else if (clk_en)
      begin
        lowleak_active[c] <= lowleak_soft[c] || !ll2[c];
        if (lowleak_soft[c] || !ll2[c])
          load_on[c] <= 1'b0;
        else if (load_force_off[c])
          load_on[c] <= 1'b0;
        else if (load_diag_on[c])
          load_on[c] <= 1'b1;
        else
          load_on[c] <= rc2[c] && !term_select[c];
        clamp_enable[c] <= rc2[c] && !term_select[c];
      end
    end

    a_ll_override: assert property (@(posedge core_clk) disable iff (!nrst)
      clk_en && (lowleak_soft[c] || !ll2[c]) |=> !load_on[c] && lowleak_active[c])
      else $error("load on during low leakage");
    a_diag_on: assert property (@(posedge core_clk) disable iff (!nrst)
      clk_en && !lowleak_soft[c] && ll2[c] && !load_force_off[c] && load_diag_on[c]
      |=> load_on[c])
      else $error("diag load not on");
    a_force_off: assert property (@(posedge core_clk) disable iff (!nrst)
      clk_en && load_force_off[c] |=> !load_on[c])
      else $error("forced-off load on");
    a_clamp_rcv: assert property (@(posedge core_clk) disable iff (!nrst)
      clamp_enable[c] |-> $past(rc2[c]) && !$past(term_select[c]))
      else $error("clamp outside receive");

    // Pin reset spares calibration so cal_word values survive a re-init; out_res_trim returns to TRIM_RST
    a_rst_fields: assert property (@(posedge core_clk)
      !nrst |=> droop_amp_sel[c] == dcscp_pkg::DROOP_RST
        && comp_deadband_sel[c] == dcscp_pkg::COMP_DEADBAND_SEL_RST
        && out_res_trim[c] == dcscp_pkg::TRIM_RST
        && level_word[c] == dcscp_pkg::LEVEL_RST)
      else $error("reset left a field set");
    a_cal_keep: assert property (@(posedge core_clk)
      !nrst && por_n && !(clk_en && cal_hit) |=> $stable(cal_word[c]))
      else $error("reset pin touched calibration");
    a_ll_release: assert property (@(posedge core_clk) disable iff (!nrst)
      clk_en && !lowleak_soft[c] && ll2[c] |=> !lowleak_active[c])
      else $error("low leakage without cause");
    a_rcv_load: assert property (@(posedge core_clk) disable iff (!nrst)
      clk_en && !lowleak_soft[c] && ll2[c] && !load_force_off[c] && !load_diag_on[c]
      |=> load_on[c] == ($past(rc2[c]) && !$past(term_select[c])))
      else $error("receive load decode wrong");
  end

  a_null_frame: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && cs_rise && f_null && !stg_valid |=> !frame_applied)
    else $error("null frame wrote");
  a_direct_apply: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && cs_rise && !f_cal && !f_null && !strobe_n |=> frame_applied)
    else $error("direct frame not applied");
  a_stage_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && cs_rise && !f_cal && !f_null && strobe_n |=> stg_valid && !frame_applied)
    else $error("staged frame misapplied");
  a_dout_copy: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en |=> serial_out == $past(shreg[dcscp_pkg::FRAME_W-1]))
    else $error("serial out mismatch");
  a_cal_write: assert property (@(posedge core_clk) disable iff (!nrst || !por_n)
    clk_en && cs_rise && f_cal && !f_bc && f_ch == 2'h0
    |=> cal_word[0] == $past(shreg[dcscp_pkg::DATA_W-1:0]))
    else $error("cal write lost");
  a_shift_in: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && cs_low && sclk_rise |=> shreg[0] == $past(din))
    else $error("shift missed");

  // Multi-step checks: a write cycle, then its visible result
  sequence s_ctl_write_both;
    clk_en && w_en && w_bc && w_reg == dcscp_pkg::REG_CTL;
  endsequence
  sequence s_both_ctl_equal;
    ctl[0] == ctl[1] && frame_applied;
  endsequence
  a_bcast_both: assert property (@(posedge core_clk) disable iff (!nrst)
    s_ctl_write_both |=> s_both_ctl_equal)
    else $error("broadcast missed a channel");

  sequence s_staged_release;
    clk_en && stg_valid && strobe_fall && !direct;
  endsequence
  a_deferred_apply: assert property (@(posedge core_clk) disable iff (!nrst)
    s_staged_release |=> frame_applied && !stg_valid)
    else $error("staged frame not released");

  sequence s_cal_frame;
    clk_en && cs_rise && f_cal && !deferred;
  endsequence
  a_cal_no_ctl: assert property (@(posedge core_clk) disable iff (!nrst)
    s_cal_frame |=> !frame_applied)
    else $error("cal frame hit control");

  // Direct path: the data word lands in the addressed level register
  sequence s_direct_level;
    clk_en && direct && !f_bc && f_ch[0] == 1'b0 && f_reg != dcscp_pkg::REG_CTL;
  endsequence
  a_direct_level: assert property (@(posedge core_clk) disable iff (!nrst)
    s_direct_level
    |=> level_word[0] == $past(shreg[dcscp_pkg::DATA_W-1:0]))
    else $error("level word not written");

  sequence s_null_frame;
    clk_en && cs_rise && f_null && !stg_valid;
  endsequence
  a_null_keep: assert property (@(posedge core_clk) disable iff (!nrst)
    s_null_frame |=> $stable(ctl) && $stable(level_word))
    else $error("null frame changed a register");
endmodule

// [include/dcscp_pkg.sv]
// Purpose: Constants for the dual-channel serial control port
// Assumes: Core clock at 100 MHz samples the serial pins
// Notes:   Frame is 8 address bits then 16 data bits
package dcscp_pkg;
  localparam int FRAME_W   = 24;
  localparam int DATA_W    = 16;
  localparam int CNT_W     = 5;
  localparam int CAL_BIT   = 23;
  localparam int BCAST_BIT = 22;
  localparam int CH_HI     = 21;
  localparam int CH_LO     = 20;
  localparam int REG_HI    = 19;
  localparam int REG_LO    = 16;
  localparam int NCHAN     = 2;
  // Control register at register index 0 (field layout chosen here)
  localparam logic [3:0] REG_CTL = 4'h0;
  localparam int DROOP_LO  = 0;
  localparam int DROOP_HI  = 2;
  localparam int COMP_DEADBAND_SEL_LO   = 3;
  localparam int COMP_DEADBAND_SEL_HI   = 5;
  localparam int TRIM_LO   = 6;
  localparam int TRIM_HI   = 9;
  localparam int LDOFF_BIT = 10;
  localparam int LDDIAG_BIT = 11;
  localparam int TERM_BIT  = 12;
  localparam int LLEAK_BIT = 13;
  localparam logic [2:0]  DROOP_RST = 3'h0;
  localparam logic [2:0]  COMP_DEADBAND_SEL_RST  = 3'h0;
  localparam logic [3:0]  TRIM_RST  = 4'h8;
  localparam logic [15:0] CTL_RST   = 16'h0200;
  localparam logic [15:0] LEVEL_RST = 16'h1333;
  localparam logic [15:0] CAL_RST   = 16'h2080;
  localparam int NREG = 11;
  localparam real SCLK_MAX_MHZ = 50.0;
  localparam real CORE_MHZ = 100.0;
endpackage

// [verif/dcscp_core_tb.sv]
// Purpose: Self-checking bench for the serial control port
// Assumes: Strobe, pins and resets driven on rising core_clk
// Notes:   Reset held 2 cycles; synchronisers reset high, receive_ctl stages low
`timescale 1ns/10ps
module dcscp_core_tb;
  logic             core_clk = 1'b0;
  logic             nrst = 1'b0;
  logic             por_n = 1'b0;
  logic             transfer_strobe_n = 1'b0;
  logic [1:0]       lowleak_pin_n = 2'h3;
  logic [1:0]       receive_ctl = 2'h0;
  logic             sclk, cs_n, serial_in, serial_out, frame_applied, seen;
  logic [1:0][2:0]  droop_amp_sel, comp_deadband_sel;
  logic [1:0][3:0]  out_res_trim;
  logic [1:0]       load_force_off, load_diag_on, term_select, lowleak_soft;
  logic [1:0]       lowleak_active, load_on, clamp_enable;
  logic [1:0][15:0] level_word, cal_word;
  logic [15:0]      ectl [2], elvl [2], ecal [2];
  logic [23:0]      rows [8] = '{24'h100c1a, 24'h401fff, 24'h05abcd, 24'h705555,
                                 24'h8f1234, 24'hc14321, 24'h000000, 24'h5a0001};
  int               err_total = 0;
  int               comparisons = 0;
  int               cycles = 0;
  always #5 core_clk = ~core_clk;
  dcscp_core dut (.core_clk(core_clk), .nrst(nrst), .por_n(por_n), .clk_en(1'b1),
    .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in), .transfer_strobe_n(transfer_strobe_n),
    .lowleak_pin_n(lowleak_pin_n), .receive_ctl(receive_ctl), .serial_out(serial_out),
    .droop_amp_sel(droop_amp_sel), .out_res_trim(out_res_trim),
    .comp_deadband_sel(comp_deadband_sel), .load_force_off(load_force_off),
    .load_diag_on(load_diag_on), .term_select(term_select), .lowleak_soft(lowleak_soft),
    .lowleak_active(lowleak_active), .load_on(load_on), .clamp_enable(clamp_enable),
    .level_word(level_word), .cal_word(cal_word), .frame_applied(frame_applied));
  dcscp_ctl_model u_ctl (.core_clk(core_clk), .serial_out(serial_out), .sclk(sclk),
    .cs_n(cs_n), .serial_in(serial_in));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      err_total++;
      end_sim;
    end
  end
  task automatic check_all;
    for (int c = 0; c < 2; c++)
    begin
      chk(24'({lowleak_soft[c], term_select[c], load_diag_on[c], load_force_off[c],
        out_res_trim[c], comp_deadband_sel[c], droop_amp_sel[c]}), 24'(ectl[c][13:0]));
      chk(24'(level_word[c]), 24'(elvl[c]));
      chk(24'(cal_word[c]), 24'(ecal[c]));
    end
  endtask
  task automatic wait_app;
    seen = 1'b0;
    for (int k = 0; k < 24 && !seen; k++)
    begin
      @(posedge core_clk);
      #1;
      seen = (frame_applied === 1'b1);
    end
    // Let registered load and clamp outputs settle
    repeat (6) @(posedge core_clk);
  endtask
  task automatic run(input logic [31:0] f, input int n);
    logic [23:0] a;
    logic        upd;
    a = f[23:0];
    upd = (a[22:20] != 3'b111) && !a[23] && !transfer_strobe_n;
    u_ctl.send(f, n);
    for (int c = 0; c < 2; c++)
      if (a[22:20] != 3'b111 && (a[22] || a[20] == c[0]))
        if (a[23])
          ecal[c] = a[15:0];
        else if (!transfer_strobe_n)
          if (a[19:16] == 4'h0)
            ectl[c] = a[15:0];
          else
            elvl[c] = a[15:0];
    wait_app;
    if (!a[23])
      chk(24'(seen), 24'(upd));
    check_all;
  endtask
  initial
  begin
    logic d13, rcv, leak;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    por_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    ectl = '{16'h0200, 16'h0200};
    elvl = '{16'h1333, 16'h1333};
    ecal = '{16'h2080, 16'h2080};
    check_all;
    for (int i = 0; i < 8; i++)
    begin
      run({8'h0, rows[i]}, 24);
      if (i > 0)
        chk(u_ctl.rx_word, rows[i - 1]);
    end
    for (int k = 0; k < 8; k++)
      run({16'h0040, 6'h0, 3'(k), 1'b1, ~3'(k), 3'(k)}, 24);
    for (int i = 0; i < 32; i++)
    begin
      receive_ctl <= {i[4], i[4] ^ i[0]};
      lowleak_pin_n <= {~(i[2] & i[4]), ~i[1] | i[3]};
      run({16'h0040, 2'h0, i[3:0], 10'h0}, 24);
      for (int c = 0; c < 2; c++)
      begin
        d13 = ectl[c][13];
        rcv = receive_ctl[c];
        leak = d13 | ~lowleak_pin_n[c];
        chk(24'(load_on[c]), 24'(!leak && !ectl[c][10] &&
          (ectl[c][11] || (rcv && !ectl[c][12]))));
        chk(24'(lowleak_active[c]), 24'(leak));
        chk(24'(clamp_enable[c]), 24'(rcv && !ectl[c][12]));
      end
    end
    run(32'h09000042, 28);
    transfer_strobe_n <= 1'b1;
    run(32'h00800777, 24);
    run(32'h00000007, 24);
    ectl[0] = 16'h0007;
    transfer_strobe_n <= 1'b0;
    wait_app;
    chk(24'(seen), 24'h1);
    check_all;
    nrst <= 1'b0;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    ectl = '{16'h0200, 16'h0200};
    elvl = '{16'h1333, 16'h1333};
    check_all;
    end_sim;
  end
endmodule

// [verif/dcscp_ctl_model.sv]
// Purpose: Tester-side writer for the serial control port
// Assumes: Serial clock of 80 ns built from core_clk edges
// Notes:   Captures serial_out at each rise as readback
`timescale 1ns/10ps
module dcscp_ctl_model (
  input  wire logic core_clk,
  input  wire logic serial_out,
  output logic      sclk,
  output logic      cs_n,
  output logic      serial_in
);
  logic [23:0] rx_word = 24'h0;
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b0;
  end
  task automatic send(input logic [31:0] frame, input int n);
    @(posedge core_clk);
    cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_in <= frame[i];
      repeat (4) @(posedge core_clk);
      sclk <= 1'b1;
      rx_word <= {rx_word[22:0], serial_out};
      repeat (4) @(posedge core_clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    cs_n <= 1'b1;
    // Released line must not keep a stale bit
    serial_in <= ~frame[0];
    @(posedge core_clk);
  endtask
endmodule
